// >>> srp_defs.svh
// serial register port constants: instruction layout, register map, timing
// assumes inclusion by the package and both ends; definitions only
//
// Behaviour
// - serial frames read and write every register
// - config bit selects 3-pin or 4-pin mode
// - 3-pin mode shares one data line both ways
// - 4-pin mode reads out on separate output
// - input bits captured on rising serial clock
// - host holds enable low two to five bytes
// - first byte instruction, then data bytes
// - bit7 direction, bits6:5 count, bits4:0 address
// - direction one reads, zero writes
// - byte count field is length minus one
// - all bytes shifted most significant bit first
// - address decrements once per data byte
// - 3-pin read leaves output line undriven
// - output low after last read bit until enable
// - host writes zero to spare register
// - bit7 of register 0x05 selects 4-pin
// - status select codes override read data output in 4-pin mode
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

`define SRP_INSTR_DIR_BIT 7
`define SRP_INSTR_CNT_HI 6
`define SRP_INSTR_CNT_LO 5
`define SRP_INSTR_ADDR_HI 4
`define SRP_NUM_REGS 32
`define SRP_REG_RESET 8'h00

`define SRP_INTERFACE_CONFIG_ADDR 5'h05
`define SRP_FOUR_WIRE_BIT 7
`define SRP_STATUS_OUTPUT_CONFIG_ADDR 5'h0e
`define SRP_SEL_HI 7
`define SRP_SEL_LO 5
`define SRP_SPARE_CONFIG_ADDR 5'h0f

`define SRP_SEL_FIXED_LOW 3'h1
`define SRP_SEL_STATUS_A 3'h2
`define SRP_SEL_STATUS_B 3'h3
`define SRP_SEL_STATUS_C 3'h4
`define SRP_SEL_SELF_TEST 3'h5

// host-side command registers on the ahb bus (byte addresses)
`define SRP_HREG_CMD 8'h00
`define SRP_HREG_WDATA 8'h04
`define SRP_HREG_RDATA 8'h08
`define SRP_HREG_STATUS 8'h0c
`define SRP_HREG_MODE 8'h10
`define SRP_LINK_DIV 8'h08

`endif

// >>> srp_pkg.sv
// serial register port shared types
// assumes srp_defs.svh is on the include path
`include "srp_defs.svh"
package srp_pkg;
   typedef enum logic [3:0] {
      SRP_S_INSTR = 4'b0001,
      SRP_S_DATA = 4'b0010,
      SRP_S_TAIL = 4'b0100,
      SRP_S_DONE = 4'b1000
   } srp_dev_state_t;
   typedef enum logic [3:0] {
      SRP_H_IDLE = 4'b0001,
      SRP_H_SETUP = 4'b0010,
      SRP_H_SHIFT = 4'b0100,
      SRP_H_END = 4'b1000
   } srp_host_state_t;
endpackage

// >>> srp_if.sv
// serial link between host controller and register port device
// assumes the bench resolves the shared data wire from the enables
interface srp_if;
   logic sclk;
   logic serial_enable_n;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic serial_data_out_o;
   logic serial_data_out_oe;
   logic sdio_i;
   logic serial_data_out_i;
   modport dev(
      input sclk,
      input serial_enable_n,
      input sdio_i,
      output sdio_dev_o,
      output sdio_dev_oe,
      output serial_data_out_o,
      output serial_data_out_oe
   );
   modport host(
      output sclk,
      output serial_enable_n,
      output sdio_host_o,
      output sdio_host_oe,
      input sdio_i,
      input serial_data_out_i
   );
endinterface

// >>> srp_device.sv
// register port device end: decodes serial frames into a register array
// assumes sclk is the link clock and serial_enable_n frames every transfer
`include "srp_defs.svh"
module srp_device (
   srp_if.dev lnk,
   input wire logic [2:0] status_flags,
   input wire logic self_test_fail_flag,
   output logic [7:0] interface_config_reg,
   output logic [7:0] status_output_config_reg
);
   ////////////////////////////////////////////////////////////////////////
   // no reset on the array: the link clock is absent outside frames
   logic [7:0] regs_ff [0:`SRP_NUM_REGS-1] = '{default: `SRP_REG_RESET};
   srp_pkg::srp_dev_state_t state_ff;
   logic [2:0] bit_ff;
   logic [1:0] byte_ff;
   logic [7:0] instr_ff;
   logic [4:0] addr_ff;
   logic [6:0] shin_ff;
   logic [7:0] shout_ff;
   logic [7:0] status_sync1_ff;
   logic [7:0] status_sync2_ff;
   logic rst_n;
   logic is_read;
   logic four_wire;
   logic [2:0] out_sel;
   logic status_override;
   logic status_bit;
   logic [7:0] instr_now;
   logic drv_ff;
   logic tail_ff;

   // enable high acts as frame reset, so the counters never outlive a frame
   assign rst_n = ~lnk.serial_enable_n;
   assign is_read = instr_ff[`SRP_INSTR_DIR_BIT];
   assign four_wire = regs_ff[`SRP_INTERFACE_CONFIG_ADDR][`SRP_FOUR_WIRE_BIT];
   assign out_sel = regs_ff[`SRP_STATUS_OUTPUT_CONFIG_ADDR][`SRP_SEL_HI:`SRP_SEL_LO];
   assign instr_now = {shin_ff, lnk.sdio_i};
   assign status_override = (out_sel >= `SRP_SEL_FIXED_LOW) && (out_sel <= `SRP_SEL_SELF_TEST);
   always_comb begin
      unique case (out_sel)
         `SRP_SEL_STATUS_A: status_bit = status_sync2_ff[0];
         `SRP_SEL_STATUS_B: status_bit = status_sync2_ff[1];
         `SRP_SEL_STATUS_C: status_bit = status_sync2_ff[2];
         `SRP_SEL_SELF_TEST: status_bit = status_sync2_ff[3];
         default: status_bit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // status inputs come from another domain; sync only for display
   always_ff @(posedge lnk.sclk) begin
      status_sync1_ff <= {4'h0, self_test_fail_flag, status_flags};
      status_sync2_ff <= status_sync1_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // rising edge capture, msb first
   always_ff @(posedge lnk.sclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= srp_pkg::SRP_S_INSTR;
         bit_ff <= 3'h0;
         byte_ff <= 2'h0;
         instr_ff <= 8'h00;
         addr_ff <= 5'h00;
         shin_ff <= 7'h00;
      end else begin
         shin_ff <= instr_now[6:0];
         bit_ff <= bit_ff + 3'h1;
         unique case (state_ff)
            srp_pkg::SRP_S_INSTR: begin
               if (bit_ff == 3'h7) begin
                  instr_ff <= instr_now;
                  addr_ff <= instr_now[`SRP_INSTR_ADDR_HI:0];
                  byte_ff <= 2'h0;
                  state_ff <= srp_pkg::SRP_S_DATA;
               end
            end
            srp_pkg::SRP_S_DATA: begin
               if (bit_ff == 3'h7) begin
                  addr_ff <= addr_ff - 5'h01;
                  byte_ff <= byte_ff + 2'h1;
                  if (byte_ff == instr_ff[`SRP_INSTR_CNT_HI:`SRP_INSTR_CNT_LO]) begin
                     state_ff <= srp_pkg::SRP_S_DONE;
                  end
               end
            end
            srp_pkg::SRP_S_TAIL: state_ff <= srp_pkg::SRP_S_DONE;
            srp_pkg::SRP_S_DONE: state_ff <= srp_pkg::SRP_S_DONE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register array; writes land on the last rising edge of each byte
   genvar gi;
   generate
      for (gi = 0; gi < `SRP_NUM_REGS; gi = gi + 1) begin : g_reg
         always_ff @(posedge lnk.sclk) begin
            if (!lnk.serial_enable_n && state_ff == srp_pkg::SRP_S_DATA && bit_ff == 3'h7 &&
                !is_read && addr_ff == 5'(gi)) begin
               regs_ff[gi] <= instr_now;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read data launches on falling edges so the host samples on the next falling edge
   always_ff @(negedge lnk.sclk or negedge rst_n) begin
      if (!rst_n) begin
         shout_ff <= 8'h00;
      end else if (state_ff == srp_pkg::SRP_S_DATA && bit_ff == 3'h0) begin
         shout_ff <= regs_ff[addr_ff];
      end else begin
         shout_ff <= {shout_ff[6:0], 1'b0};
      end
   end

   // line turns round on the falling edge, when the host lets go of it
   always_ff @(negedge lnk.sclk or negedge rst_n) begin
      if (!rst_n) begin
         drv_ff <= 1'b0;
         tail_ff <= 1'b0;
      end else begin
         drv_ff <= is_read && (state_ff == srp_pkg::SRP_S_DATA ||
            state_ff == srp_pkg::SRP_S_DONE);
         // last bit stays up until the final falling edge
         tail_ff <= state_ff == srp_pkg::SRP_S_DONE;
      end
   end

   always_comb begin
      lnk.sdio_dev_o = 1'b0;
      lnk.sdio_dev_oe = 1'b0;
      lnk.serial_data_out_o = 1'b0;
      lnk.serial_data_out_oe = 1'b0;
      if (four_wire) begin
         if (status_override) begin
            lnk.serial_data_out_o = status_bit;
            lnk.serial_data_out_oe = 1'b1;
         end else if (drv_ff) begin
            // tail drives low until enable rises
            lnk.serial_data_out_o = tail_ff ? 1'b0 : shout_ff[7];
            lnk.serial_data_out_oe = 1'b1;
         end
      end else if (drv_ff) begin
         lnk.sdio_dev_o = tail_ff ? 1'b0 : shout_ff[7];
         lnk.sdio_dev_oe = 1'b1;
      end
   end

   assign interface_config_reg = regs_ff[`SRP_INTERFACE_CONFIG_ADDR];
   assign status_output_config_reg = regs_ff[`SRP_STATUS_OUTPUT_CONFIG_ADDR];
endmodule

// >>> srp_host.sv
// host end: ahb-lite slave commands serial frames on the link
// assumes one ahb master, single word transfers
//
// Implementation choice: the AHB-Lite interface to the registers.
`include "srp_defs.svh"
module srp_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   srp_if.host lnk
);
   ////////////////////////////////////////////////////////////////////////
   logic wr_pend_ff;
   logic [7:0] addr_ph_ff;
   logic [7:0] cmd_ff;
   logic [31:0] wdata_ff;
   logic [31:0] rdata_ff;
   logic four_wire_ff;
   logic start_ff;
   logic busy_ff;
   logic [31:0] nxt_hrdata;
   srp_pkg::srp_host_state_t state_ff;
   logic [2:0] div_ff;
   logic sclk_ff;
   logic sen_n_ff;
   logic sdo_ff;
   logic sdo_oe_ff;
   logic [39:0] shift_ff;
   logic [5:0] bits_left_ff;
   logic [5:0] bits_total;
   logic [5:0] read_start;
   logic [1:0] sync1_ff;
   logic [1:0] sync2_ff;
   logic rx_bit;
   logic go;

   assign hresp = 1'b0;
   assign hreadyout = 1'b1;
   assign go = hsel && htrans[1] && hready;
   // length from byte count field: instruction plus count+1 bytes
   assign bits_total = 6'd8 + {1'b0, cmd_ff[6:5], 3'b000} + 6'd8;
   assign read_start = bits_total - 6'd8;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ph_ff <= 8'h00;
      end else begin
         wr_pend_ff <= go && hwrite;
         if (go) addr_ph_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         four_wire_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         start_ff <= wr_pend_ff && addr_ph_ff == `SRP_HREG_CMD && !busy_ff;
         if (wr_pend_ff) begin
            unique case (addr_ph_ff)
               `SRP_HREG_CMD: if (!busy_ff) cmd_ff <= hwdata[7:0];
               `SRP_HREG_WDATA: wdata_ff <= hwdata;
               `SRP_HREG_MODE: four_wire_ff <= hwdata[0];
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      nxt_hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
         `SRP_HREG_CMD: nxt_hrdata = {24'h00_0000, cmd_ff};
         `SRP_HREG_WDATA: nxt_hrdata = wdata_ff;
         `SRP_HREG_RDATA: nxt_hrdata = rdata_ff;
         `SRP_HREG_STATUS: nxt_hrdata = {31'h0000_0000, busy_ff};
         `SRP_HREG_MODE: nxt_hrdata = {31'h0000_0000, four_wire_ff};
         default: nxt_hrdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0000_0000;
      else if (go && !hwrite) hrdata <= nxt_hrdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // returned data is sampled on our own falling sclk, so sync it first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 2'b00;
         sync2_ff <= 2'b00;
      end else begin
         sync1_ff <= {lnk.serial_data_out_i, lnk.sdio_i};
         sync2_ff <= sync1_ff;
      end
   end
   assign rx_bit = four_wire_ff ? sync2_ff[1] : sync2_ff[0];

   ////////////////////////////////////////////////////////////////////////
   // link clock is divided from hclk; data changes on falling sclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= srp_pkg::SRP_H_IDLE;
         div_ff <= 3'h0;
         sclk_ff <= 1'b0;
         sen_n_ff <= 1'b1;
         sdo_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
         shift_ff <= 40'h00_0000_0000;
         bits_left_ff <= 6'h00;
         rdata_ff <= 32'h0000_0000;
         busy_ff <= 1'b0;
      end else begin
         div_ff <= div_ff + 3'h1;
         unique case (state_ff)
            srp_pkg::SRP_H_IDLE: begin
               sclk_ff <= 1'b0;
               if (start_ff) begin
                  busy_ff <= 1'b1;
                  // msb first; data bytes follow in decreasing address order
                  shift_ff <= {cmd_ff, wdata_ff};
                  bits_left_ff <= bits_total;
                  sen_n_ff <= 1'b0;
                  div_ff <= 3'h0;
                  state_ff <= srp_pkg::SRP_H_SETUP;
               end
            end
            srp_pkg::SRP_H_SETUP: begin
               sdo_ff <= shift_ff[39];
               sdo_oe_ff <= 1'b1;
               shift_ff <= {shift_ff[38:0], 1'b0};
               state_ff <= srp_pkg::SRP_H_SHIFT;
            end
            srp_pkg::SRP_H_SHIFT: begin
               if (div_ff == 3'h3) begin
                  sclk_ff <= 1'b1;
                  // sample at falling edge; sync lag fits half period
               end else if (div_ff == 3'h7) begin
                  sclk_ff <= 1'b0;
                  if (cmd_ff[7] && bits_left_ff <= read_start) begin
                     rdata_ff <= {rdata_ff[30:0], rx_bit};
                  end
                  bits_left_ff <= bits_left_ff - 6'h01;
                  if (bits_left_ff == 6'h01) begin
                     state_ff <= srp_pkg::SRP_H_END;
                  end else begin
                     sdo_ff <= shift_ff[39];
                     shift_ff <= {shift_ff[38:0], 1'b0};
                     // release shared line for read data in 3-pin mode
                     sdo_oe_ff <= !(cmd_ff[7] && bits_left_ff <= read_start + 6'h01 && !four_wire_ff);
                  end
               end
            end
            srp_pkg::SRP_H_END: begin
               sen_n_ff <= 1'b1;
               sdo_oe_ff <= 1'b0;
               busy_ff <= 1'b0;
               state_ff <= srp_pkg::SRP_H_IDLE;
            end
         endcase
      end
   end

   assign lnk.sclk = sclk_ff;
   assign lnk.serial_enable_n = sen_n_ff;
   assign lnk.sdio_host_o = sdo_ff;
   assign lnk.sdio_host_oe = sdo_oe_ff;
endmodule

// >>> srp_monitor.sv
// checker for the serial link between host end and device end
// assumes hclk drives the host divider and hresetn resets the host end
module srp_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic serial_enable_n,
   input wire logic sdio_host_o,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe,
   input wire logic serial_data_out_o,
   input wire logic serial_data_out_oe
);
   logic sclk_d_ff;
   logic [5:0] edge_cnt_ff;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////
   // link edges counted in the fast domain, sclk being a divided hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sclk_d_ff <= 1'b0;
      else sclk_d_ff <= sclk;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) edge_cnt_ff <= 6'h00;
      else if (serial_enable_n) edge_cnt_ff <= 6'h00;
      else if (sclk && !sclk_d_ff) edge_cnt_ff <= edge_cnt_ff + 6'h01;
   end
   ////////////////////////////////////////
   a_line_no_clash: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the shared data line");
   a_outs_exclusive: assert property (!(sdio_dev_oe && serial_data_out_oe))
      else $error("device drives both data lines");
   a_dev_idle_quiet: assert property (serial_enable_n && $past(serial_enable_n) |-> !sdio_dev_oe)
      else $error("device drives data line outside a frame");
   a_instr_from_host: assert property ($rose(sclk) && edge_cnt_ff < 6'h08 |->
      sdio_host_oe && !sdio_dev_oe)
      else $error("instruction bit not driven by host");
   a_sclk_shape: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("link clock high phase wrong");
   a_data_stable: assert property ($rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
      else $error("host data moved at rising link clock");
   a_sclk_in_frame: assert property (sclk |-> !serial_enable_n)
      else $error("link clock outside a frame");
   a_frame_bytes: assert property ($rose(serial_enable_n) |->
      edge_cnt_ff inside {6'h10, 6'h18, 6'h20, 6'h28})
      else $error("frame not two to five whole bytes");
   a_tail_low: assert property ($rose(serial_enable_n) && $past(serial_data_out_oe) |->
      !$past(serial_data_out_o))
      else $error("output line not low before frame end");
   c_long_frame: cover property ($rose(serial_enable_n) && edge_cnt_ff == 6'h28);
   c_short_frame: cover property ($rose(serial_enable_n) && edge_cnt_ff == 6'h10);
   c_sdo_driven: cover property (serial_data_out_oe);
endmodule

// >>> serial_register_port_test.sv
// bench: ahb master drives the host end, which talks to the device end
// assumes zero wait state okay answers and a link clock made by the host
`include "srp_defs.svh"
module serial_register_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, four, sdo_used;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] icfg, scfg;
   logic [39:0] wire_bits;
   logic [31:0] last_wd;
   int wire_cnt, fails, n_checks, cyc;
   srp_if lnk ();
   srp_host srp_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk));
   srp_device srp_device_inst (.lnk(lnk), .status_flags(3'h0), .self_test_fail_flag(1'b0),
      .interface_config_reg(icfg), .status_output_config_reg(scfg));
   srp_monitor srp_monitor_inst (.hclk(hclk), .hresetn(hresetn), .sclk(lnk.sclk),
      .serial_enable_n(lnk.serial_enable_n), .sdio_host_o(lnk.sdio_host_o),
      .sdio_host_oe(lnk.sdio_host_oe), .sdio_dev_o(lnk.sdio_dev_o),
      .sdio_dev_oe(lnk.sdio_dev_oe), .serial_data_out_o(lnk.serial_data_out_o),
      .serial_data_out_oe(lnk.serial_data_out_oe));
   // shared line has a pull-down; the output line has none, so show the inverse
   assign lnk.sdio_i = lnk.sdio_host_oe ? lnk.sdio_host_o : lnk.sdio_dev_oe ? lnk.sdio_dev_o : 1'b0;
   assign lnk.serial_data_out_i = lnk.serial_data_out_oe ? lnk.serial_data_out_o
      : ~lnk.serial_data_out_o;
   ////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         print_verdict();
      end
   end
   always @(posedge hclk) if (lnk.serial_data_out_oe === 1'b1) sdo_used <= 1'b1;
   always @(posedge lnk.sclk) if (!lnk.serial_enable_n) begin
      wire_bits <= {wire_bits[38:0], lnk.sdio_i};
      wire_cnt <= wire_cnt + 1;
   end
   always @(negedge lnk.serial_enable_n) wire_cnt <= 0;
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (wr && a == `SRP_HREG_WDATA) last_wd = wd;
   endtask
   task automatic started();
      int k;
      k = 0;
      while (lnk.serial_enable_n !== 1'b0 && k < 40) begin
         @(posedge hclk);
         k++;
      end
   endtask
   task automatic idle();
      logic [31:0] s;
      int k;
      s = 32'h0000_0001;
      k = 0;
      while (s[0] !== 1'b0 && k < 400) begin
         ahb(1'b0, `SRP_HREG_STATUS, 32'h0000_0000, s);
         k++;
      end
      chk("busy clears", 40'h00, 40'(s[0]));
   endtask
   task automatic frame(input logic rd, input logic [4:0] a, input int n,
      input logic [31:0] wd, output logic [31:0] rv);
      logic [7:0] ins;
      logic [31:0] s;
      logic [39:0] msk, dat, e;
      ins = {rd, 2'(n - 1), a};
      msk = (40'h01 << (8 * n)) - 40'h01;
      idle();
      if (!rd) ahb(1'b1, `SRP_HREG_WDATA, wd, s);
      ahb(1'b1, `SRP_HREG_CMD, {24'h00_0000, ins}, s);
      started();
      idle();
      ahb(1'b0, `SRP_HREG_RDATA, 32'h0000_0000, rv);
      rv = rv & msk[31:0];
      // in 4-pin reads the host still shifts its data word out
      dat = !rd ? 40'(wd >> (32 - 8 * n)) : four ? 40'(last_wd >> (32 - 8 * n)) : 40'(rv);
      e = ({32'h0000_0000, ins} << (8 * n)) | dat;
      chk("link bit count", 40'(8 * n + 8), 40'(wire_cnt));
      chk("link frame bits", e, wire_bits & ((msk << 8) | 40'hff));
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] s;
      chk("idle link", 40'h08, 40'({lnk.sclk, lnk.serial_enable_n, lnk.sdio_host_oe,
         lnk.sdio_dev_oe, lnk.serial_data_out_oe}));
      chk("config regs", 40'h00, 40'({icfg, scfg}));
      frame(1'b1, 5'h0f, 1, 32'h0000_0000, s);
      chk("spare reg", 40'h00, 40'(s));
      frame(1'b0, 5'h0f, 1, 32'h0000_0000, s);
      $display("test reset done");
   endtask
   task automatic t_lengths();
      logic [31:0] s;
      sdo_used = 1'b0;
      frame(1'b0, 5'h03, 4, 32'h1122_3344, s);
      for (int n = 1; n <= 4; n++) begin
         frame(1'b1, 5'h03, n, 32'h0000_0000, s);
         chk("read length", 40'(32'h1122_3344 >> (32 - 8 * n)), 40'(s));
      end
      frame(1'b1, 5'h02, 2, 32'h0000_0000, s);
      chk("read from two", 40'h2233, 40'(s));
      chk("three pin sdo", 40'h00, 40'(sdo_used));
      $display("test lengths done");
   endtask
   task automatic t_busy();
      logic [31:0] s;
      ahb(1'b1, `SRP_HREG_WDATA, 32'h5a00_0000, s);
      ahb(1'b1, `SRP_HREG_CMD, 32'h0000_000a, s);
      started();
      ahb(1'b0, `SRP_HREG_STATUS, 32'h0000_0000, s);
      chk("busy flag", 40'h01, 40'(s[0]));
      ahb(1'b1, `SRP_HREG_CMD, 32'h0000_0009, s);
      frame(1'b1, 5'h0a, 1, 32'h0000_0000, s);
      chk("first cmd", 40'h5a, 40'(s));
      frame(1'b1, 5'h09, 1, 32'h0000_0000, s);
      chk("busy cmd dropped", 40'h00, 40'(s));
      $display("test busy done");
   endtask
   task automatic t_abort();
      logic [31:0] s;
      ahb(1'b1, `SRP_HREG_WDATA, 32'hdead_beef, s);
      ahb(1'b1, `SRP_HREG_CMD, 32'h0000_007f, s);
      started();
      repeat (100) @(posedge hclk);
      hresetn <= 1'b0;
      last_wd = 32'h0000_0000;
      repeat (3) @(posedge hclk);
      chk("enable after cut", 40'h01, 40'(lnk.serial_enable_n));
      hresetn <= 1'b1;
      frame(1'b0, 5'h1e, 1, 32'hc300_0000, s);
      frame(1'b1, 5'h1e, 1, 32'h0000_0000, s);
      chk("after cut", 40'hc3, 40'(s));
      $display("test abort done");
   endtask
   task automatic t_four();
      logic [31:0] s;
      frame(1'b0, 5'h05, 1, 32'h8000_0000, s);
      chk("four wire bit", 40'h80, 40'(icfg));
      ahb(1'b1, `SRP_HREG_MODE, 32'h0000_0001, s);
      ahb(1'b0, `SRP_HREG_MODE, 32'h0000_0000, s);
      chk("mode reg", 40'h01, 40'(s[0]));
      four = 1'b1;
      for (int c = 0; c < 8; c++) begin
         frame(1'b0, 5'h0e, 1, {c[2:0], 29'h0000_0000}, s);
         chk("select reg", 40'({c[2:0], 5'h00}), 40'(scfg));
         sdo_used = 1'b0;
         frame(1'b1, 5'h05, 1, 32'h0000_0000, s);
         chk("four pin read", (c == 0 || c > 5) ? 40'h80 : 40'h00, 40'(s));
         chk("sdo used", 40'h01, 40'(sdo_used));
      end
      frame(1'b0, 5'h05, 1, 32'h0000_0000, s);
      ahb(1'b1, `SRP_HREG_MODE, 32'h0000_0000, s);
      four = 1'b0;
      frame(1'b1, 5'h05, 1, 32'h0000_0000, s);
      chk("back to three pin", 40'h00, 40'(s));
      $display("test four pin done");
   endtask
   task automatic t_unmapped();
      logic [31:0] s;
      ahb(1'b1, 8'h14, 32'h0000_0001, s);
      ahb(1'b0, `SRP_HREG_MODE, 32'h0000_0000, s);
      chk("mode untouched", 40'h00, 40'(s[0]));
      chk("okay response", 40'h00, 40'(hresp));
      $display("test unmapped done");
   endtask
   ////////////////////////////////////////
   initial begin
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      hresetn = 1'b0;
      four = 1'b0;
      sdo_used = 1'b0;
      wire_cnt = 0;
      wire_bits = 40'h00;
      last_wd = 32'h0000_0000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_lengths();
      t_busy();
      t_abort();
      t_four();
      t_unmapped();
      print_verdict();
   end
endmodule
